//--- verilog/dpam_pkg.sv
// How it works
// - host holds slave busy high, low blocks
// - host stalls a memory access while busy low; token accesses do not wait
// - cascaded busy flags joined by AND
// - token access: memory select off, token select on
package dpam_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 18;
   localparam int TOKEN_IDX_W = 3;
   localparam int TOKEN_BIT = 0;
   localparam logic [17:0] LEFT_MAILBOX = 18'h3fffe;
   localparam logic [17:0] RIGHT_MAILBOX = 18'h3ffff;
   localparam int CLK_MHZ = 125;
   localparam int T_APS_NS = 5;
   localparam int T_BAA_NS = 15;
   localparam int T_PULSE_NS = 15;
   localparam int SETUP_CYC_I = (T_APS_NS * CLK_MHZ + 999) / 1000;
   localparam int BUSY_CYC_I = (T_BAA_NS * CLK_MHZ + 999) / 1000;
   localparam int PULSE_CYC_I = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] SETUP_CYC = 4'(SETUP_CYC_I < 1 ? 1 : SETUP_CYC_I);
   localparam logic [3:0] BUSY_CYC = 4'(BUSY_CYC_I < 1 ? 1 : BUSY_CYC_I);
   localparam logic [3:0] PULSE_CYC = 4'(PULSE_CYC_I < 1 ? 1 : PULSE_CYC_I);
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   typedef enum logic [1:0] {
      DPAM_IDLE,
      DPAM_SETTLE,
      DPAM_STROBE,
      DPAM_RECOVER
   } dpam_state_t;
endpackage : dpam_pkg

//--- verilog/dpam_busy_join.sv
module dpam_busy_join #(
   parameter int NDEV = 2
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [NDEV-1:0] flags_n,
   output logic joined_n
);
   logic [NDEV:0] chain;

   assign chain[0] = 1'b1;
   genvar i;
   generate
      for (i = 0; i < NDEV; i++) begin : g_and
         assign chain[i+1] = chain[i] & flags_n[i];
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         joined_n <= 1'b1;
      end else if (clk_en) begin
         joined_n <= chain[NDEV];
      end
   end

   join_and_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      $past(clk_en) && $past(rst_b) |-> joined_n == &$past(flags_n))
      else $error("joined busy is not the and of device flags");
endmodule : dpam_busy_join

//--- verilog/dpam_port_ctrl.sv
module dpam_port_ctrl #(
   parameter int NDEV = 2,
   parameter int NSLAVE = 1
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_token,
   input wire logic [dpam_pkg::ADDR_W-1:0] req_addr,
   input wire logic [dpam_pkg::DATA_W-1:0] req_wdata,
   output logic rsp_valid,
   output logic [dpam_pkg::DATA_W-1:0] rsp_rdata,
   input wire logic block_writes,
   output logic [NSLAVE-1:0] slave_contention_flag_n,
   input wire logic [NDEV-1:0] contention_flag_n,
   input wire logic mailbox_irq_n,
   output logic mail_pending,
   output logic mem_select_n,
   output logic token_space_select_n,
   output logic out_enable_n,
   output logic write_n,
   output logic [dpam_pkg::ADDR_W-1:0] addr,
   output logic [dpam_pkg::DATA_W-1:0] data_out,
   output logic data_drive_n,
   input wire logic [dpam_pkg::DATA_W-1:0] data_in
);
   dpam_pkg::dpam_state_t state;
   logic [3:0] cnt;
   logic op_write;
   logic op_token;
   logic busy_joined_n;

   ////////////////////////////////////////////////////////////////////////////////
   // busy of cascaded devices
   dpam_busy_join #(
      .NDEV(NDEV)
   ) u_join (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .flags_n(contention_flag_n),
      .joined_n(busy_joined_n)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // slave busy pins and mailbox
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         slave_contention_flag_n <= '1;
      end else if (clk_en) begin
         slave_contention_flag_n <= {NSLAVE{!block_writes}};
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         mail_pending <= 1'b0;
      end else if (clk_en) begin
         mail_pending <= !mailbox_irq_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // access sequencer
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state <= dpam_pkg::DPAM_IDLE;
         cnt <= dpam_pkg::CNT_ZERO;
         op_write <= 1'b0;
         op_token <= 1'b0;
         req_ready <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
         mem_select_n <= 1'b1;
         token_space_select_n <= 1'b1;
         out_enable_n <= 1'b1;
         write_n <= 1'b1;
         addr <= '0;
         data_out <= '0;
         data_drive_n <= 1'b1;
      end else if (clk_en) begin
         rsp_valid <= 1'b0;
         case (state)
            dpam_pkg::DPAM_IDLE: begin
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  op_write <= req_write;
                  op_token <= req_token;
                  addr <= req_addr;
                  data_out <= req_wdata;
                  mem_select_n <= req_token;
                  token_space_select_n <= !req_token;
                  cnt <= req_token ? dpam_pkg::SETUP_CYC : dpam_pkg::BUSY_CYC;
                  state <= dpam_pkg::DPAM_SETTLE;
               end
            end
            dpam_pkg::DPAM_SETTLE: begin
               if (cnt != dpam_pkg::CNT_ZERO) begin
                  cnt <= cnt - dpam_pkg::CNT_ONE;
               end else if (op_token || busy_joined_n) begin
                  write_n <= !op_write;
                  out_enable_n <= op_write;
                  data_drive_n <= !op_write;
                  cnt <= dpam_pkg::PULSE_CYC;
                  state <= dpam_pkg::DPAM_STROBE;
               end
            end
            dpam_pkg::DPAM_STROBE: begin
               cnt <= cnt - dpam_pkg::CNT_ONE;
               if (cnt == dpam_pkg::CNT_ONE) begin
                  if (!op_write) begin
                     rsp_rdata <= data_in;
                  end
                  rsp_valid <= 1'b1;
                  write_n <= 1'b1;
                  out_enable_n <= 1'b1;
                  mem_select_n <= 1'b1;
                  token_space_select_n <= 1'b1;
                  state <= dpam_pkg::DPAM_RECOVER;
               end
            end
            dpam_pkg::DPAM_RECOVER: begin
               data_drive_n <= 1'b1;
               req_ready <= 1'b1;
               state <= dpam_pkg::DPAM_IDLE;
            end
            default: begin
               state <= dpam_pkg::DPAM_IDLE;
               req_ready <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   select_excl_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      !(mem_select_n == 1'b0 && token_space_select_n == 1'b0))
      else $error("memory and token selects low together");

   token_route_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      $fell(token_space_select_n) |-> mem_select_n)
      else $error("token access without memory select high");

   stall_busy_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      $fell(write_n) && !mem_select_n |-> $past(busy_joined_n))
      else $error("write strobe started while busy low");

   slave_hold_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      $past(clk_en) && $past(rst_b) |-> slave_contention_flag_n[0] == !$past(block_writes))
      else $error("slave busy level does not follow block request");

   ////////////////////////////////////////////////////////////////////////////////
   // strobe width monitor and bus checks
   logic [3:0] strobe_len;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         strobe_len <= dpam_pkg::CNT_ZERO;
      end else if (clk_en) begin
         if (!write_n || !out_enable_n) begin
            strobe_len <= strobe_len + dpam_pkg::CNT_ONE;
         end else begin
            strobe_len <= dpam_pkg::CNT_ZERO;
         end
      end
   end

   strobe_excl_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      !(write_n == 1'b0 && out_enable_n == 1'b0))
      else $error("write and read strobes low together");

   strobe_sel_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      !write_n || !out_enable_n |-> !mem_select_n || !token_space_select_n)
      else $error("strobe low with no select low");

   drive_dir_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      !data_drive_n |-> out_enable_n)
      else $error("host drives data during a read");

   addr_hold_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (!mem_select_n || !token_space_select_n)
         && $past(!mem_select_n || !token_space_select_n) |-> $stable(addr))
      else $error("address moved while selected");

   data_hold_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      !data_drive_n && $past(!data_drive_n) |-> $stable(data_out))
      else $error("write data moved while driven");

   stall_hold_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en && state == dpam_pkg::DPAM_SETTLE && cnt == dpam_pkg::CNT_ZERO && !op_token
         && !busy_joined_n |=> write_n && out_enable_n)
      else $error("strobe started during busy stall");

   strobe_len_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(write_n) || $rose(out_enable_n) |-> strobe_len == dpam_pkg::PULSE_CYC)
      else $error("strobe width differs from pulse count");

   rsp_pulse_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en && rsp_valid |=> !rsp_valid)
      else $error("response valid longer than one cycle");

   rsp_end_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(rsp_valid) |-> mem_select_n && token_space_select_n)
      else $error("response given while still selected");

   ready_idle_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      req_ready |-> state == dpam_pkg::DPAM_IDLE)
      else $error("ready high outside idle");

   take_sel_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      $fell(req_ready) |-> !mem_select_n || !token_space_select_n)
      else $error("request taken without a select");

   mail_follow_a:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      $past(clk_en) && $past(rst_b) |-> mail_pending == !$past(mailbox_irq_n))
      else $error("mail pending does not follow device irq");
endmodule : dpam_port_ctrl

//--- tb/dpam_dev_model.sv
module dpam_dev_model (
   input wire logic mem_select_n,
   input wire logic token_space_select_n,
   input wire logic out_enable_n,
   input wire logic write_n,
   input wire logic [17:0] addr,
   input wire logic [17:0] data_out,
   input wire logic o_sel,
   input wire logic [17:0] o_addr,
   input wire logic o_mail,
   input wire logic o_wr,
   input wire logic [3:0] o_tok,
   input wire logic slave_busy_n,
   output logic busy_n,
   output logic irq_n,
   output logic far_irq_n,
   output logic [17:0] data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [17:0] mem [2**18];
   logic [1:0] own [8] = '{default: 0};
   logic [7:0] req [3] = '{default: 0};
   logic [17:0] val;
   logic far_first = 0;
   task automatic tok(input int s, input int i, input logic v);
      if (!v) begin
         if (own[i] == 0)
            own[i] = 2'(s);
         else if (own[i] != s)
            req[s][i] = 1;
      end else if (own[i] == s) begin
         own[i] = req[3 - s][i] ? 2'(3 - s) : 2'd0;
         req[3 - s][i] = 0;
      end
   endtask : tok
   ////////////////////////////////
   always @(negedge mem_select_n) far_first = o_sel;
   assign busy_n = !(far_first && o_sel && !mem_select_n && addr == o_addr);
   assign val = !token_space_select_n ? {18{own[addr[2:0]] != 2'd1}} : mem[addr];
   assign data_in = out_enable_n ? ~val : val;
   initial irq_n = 1;
   always @(posedge o_mail) irq_n = 0;
   always @(negedge out_enable_n)
      if (!mem_select_n && addr == dpam_pkg::LEFT_MAILBOX)
         irq_n = 1;
   always @(negedge write_n)
      if (!mem_select_n && busy_n && slave_busy_n)
         mem[addr] = data_out;
      else if (!token_space_select_n)
         tok(1, addr[2:0], data_out[0]);
   always @(posedge o_wr) tok(2, o_tok[2:0], o_tok[3]);
   initial far_irq_n = 1;
   always @(negedge write_n)
      if (!mem_select_n && busy_n && addr == dpam_pkg::RIGHT_MAILBOX)
         far_irq_n = 0;
endmodule : dpam_dev_model

//--- tb/dual_port_arbitration_mailbox_tb_top.sv
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module dual_port_arbitration_mailbox_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, rst_b = 0, clk_en = 1, req_valid = 0, req_write = 0, req_token = 0;
   logic block_writes = 0, o_sel = 0, o_mail = 0, o_wr = 0, busy2_n = 1, req_ready, rsp_valid;
   logic mail_pending, mem_select_n, token_space_select_n, out_enable_n, write_n, data_drive_n;
   logic busy_n, irq_n, far_irq_n;
   logic [0:0] slave_contention_flag_n;
   logic [2:0] ti;
   logic [3:0] o_tok = 0;
   logic [17:0] req_addr = 0, req_wdata = 0, o_addr = 0, rsp_rdata, addr, data_out;
   logic [17:0] data_in, rd, ev;
   logic [2:0] seq [10] = '{0, 4, 3, 1, 6, 3, 5, 7, 0, 3};
   int mismatches = 0, num_checks = 0, n;
   integer seed = 32'h931ad0cb;
   dpam_port_ctrl #(.NDEV(2), .NSLAVE(1)) uut (.core_clk(core_clk), .rst_b(rst_b),
      .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_token(req_token), .req_addr(req_addr),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .block_writes(block_writes), .slave_contention_flag_n(slave_contention_flag_n),
      .contention_flag_n({busy2_n, busy_n}), .mailbox_irq_n(irq_n),
      .mail_pending(mail_pending), .mem_select_n(mem_select_n),
      .token_space_select_n(token_space_select_n), .out_enable_n(out_enable_n),
      .write_n(write_n), .addr(addr), .data_out(data_out), .data_drive_n(data_drive_n),
      .data_in(data_in));
   dpam_dev_model dev (.mem_select_n(mem_select_n),
      .token_space_select_n(token_space_select_n), .out_enable_n(out_enable_n),
      .write_n(write_n), .addr(addr), .data_out(data_out), .o_sel(o_sel), .o_addr(o_addr),
      .o_mail(o_mail), .o_wr(o_wr), .o_tok(o_tok),
      .slave_busy_n(slave_contention_flag_n[0]), .busy_n(busy_n), .irq_n(irq_n),
      .far_irq_n(far_irq_n), .data_in(data_in));
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   task automatic acc(input logic w, t, input logic [17:0] a, d);
      @(posedge core_clk);
      req_valid <= 1;
      req_write <= w;
      req_token <= t;
      req_addr <= a;
      req_wdata <= d;
      @(posedge core_clk);
      req_valid <= 0;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (!rsp_valid && n < 200);
      if (rsp_valid !== 1'b1) begin
         mismatches++;
         conclude();
      end else begin
         rd = rsp_rdata;
      end
   endtask : acc
   ////////////////////////////////
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      repeat (4) @(posedge core_clk);
      rst_b <= 1;
      for (int i = 0; i < 6; i++) begin
         ev = 18'($random(seed));
         o_addr = (i < 2) ? dpam_pkg::LEFT_MAILBOX + 18'(i) : 18'($random(seed));
         acc(1, 0, o_addr, ev);
         `CHK(n, int'(dpam_pkg::BUSY_CYC) + int'(dpam_pkg::PULSE_CYC) + 2)
         acc(0, 0, o_addr, 18'h0);
         `CHK(rd, ev)
      end
      `CHK(far_irq_n, 1'b0)
      $display("memory test done");
      o_mail <= 1;
      repeat (3) @(negedge core_clk);
      `CHK(mail_pending, 1'b1)
      acc(0, 0, dpam_pkg::LEFT_MAILBOX, 18'h0);
      `CHK(mail_pending, 1'b0)
      $display("mailbox test done");
      for (int k = 0; k < 2; k++) begin
         @(posedge core_clk);
         o_addr <= 18'(k + 9);
         o_sel <= (k == 0);
         busy2_n <= (k == 0);
         fork
            acc(1, 0, 18'(k + 9), 18'h2aaaa);
            begin
               repeat (20) @(posedge core_clk);
               o_sel <= 0;
               busy2_n <= 1;
            end
         join
         `CHK(n > 15, 1'b1)
         acc(0, 0, 18'(k + 9), 18'h0);
         `CHK(rd, 18'h2aaaa)
      end
      @(posedge core_clk);
      o_addr <= 18'hb;
      fork
         acc(1, 0, 18'hb, 18'h15555);
         begin
            repeat (4) @(posedge core_clk);
            o_sel <= 1;
         end
      join
      `CHK(n, int'(dpam_pkg::BUSY_CYC) + int'(dpam_pkg::PULSE_CYC) + 2)
      o_sel <= 0;
      acc(0, 0, 18'hb, 18'h0);
      `CHK(rd, 18'h15555)
      $display("busy test done");
      ti = 3'($random(seed));
      foreach (seq[j]) begin
         if (seq[j][2]) begin
            o_tok <= {seq[j][1], ti};
            o_wr <= 1;
            @(posedge core_clk);
            o_wr <= 0;
         end else
            acc(1, 1, {15'($random(seed)), ti}, {17'($random(seed)), seq[j][1]});
         acc(0, 1, {15'h0, ti}, 18'h0);
         `CHK(rd, {18{seq[j][0]}})
      end
      $display("token test done");
      @(posedge core_clk);
      block_writes <= 1;
      repeat (2) @(negedge core_clk);
      `CHK(slave_contention_flag_n, 1'b0)
      acc(1, 0, 18'h9, 18'h15555);
      acc(0, 0, 18'h9, 18'h0);
      `CHK(rd, 18'h2aaaa)
      @(posedge core_clk);
      clk_en <= 0;
      block_writes <= 0;
      repeat (3) @(negedge core_clk);
      `CHK(slave_contention_flag_n, 1'b0)
      @(posedge core_clk);
      clk_en <= 1;
      repeat (2) @(negedge core_clk);
      `CHK(slave_contention_flag_n, 1'b1)
      $display("slave test done");
      conclude();
   end
endmodule : dual_port_arbitration_mailbox_tb_top
